// file: logic/lsbca_defines.svh
// register offsets, field positions, reset values and cycle counts
// assumes a 32-bit AHB-Lite slave decode on haddr[7:0]
// How it works
// - file forms write working register when selector set, else the file register.
// - AND and inclusive OR on file/working, register pair, or literal operands.
// - exclusive OR uses the same operand forms as AND.
// - arithmetic right shift keeps sign; last bit out goes to carry.
// - logical right shift fills zeros; last bit out goes to carry.
// - left shift fills zeros; last top bit out goes to carry.
// - rotate through carry moves seventeen bits by one place.
// - plain rotate wraps sixteen bits by one place, carry untouched.
// - file bit test-and-set puts complement of bit into zero flag then sets it.
// - working register bit tests report into carry; set variant then sets.
// - sign change scan finds first bit below top differing from sign.
// - first-one scans from top and from bottom write found position.
// - compare subtracts second operand from first for flags only.
// - compare with borrow also subtracts inverted carry for chaining.
// - bit test skips next instruction on clear, or on set variant.
// - register compare skips on signed greater, signed less or unequal.
// - skip costs one cycle untaken, two or three when taken.
// - compare-branch on equal, unequal, signed greater or signed less.
// - enhanced core branch costs one cycle untaken, five taken.
// - enhanced core adds one cycle for peripheral register access in file forms.
`ifndef LSBCA_DEFINES_SVH
`define LSBCA_DEFINES_SVH

`define LSBCA_OFF_CTRL 8'h00
`define LSBCA_OFF_OPA 8'h04
`define LSBCA_OFF_OPB 8'h08
`define LSBCA_OFF_LIT 8'h0C
`define LSBCA_OFF_FILE 8'h10
`define LSBCA_OFF_DEFWR 8'h14
`define LSBCA_OFF_DEST 8'h18
`define LSBCA_OFF_STAT 8'h1C
`define LSBCA_OFF_CYC 8'h20

`define LSBCA_CTRL_W 15
`define LSBCA_ST_C 0
`define LSBCA_ST_Z 1
`define LSBCA_ST_OV 2
`define LSBCA_ST_N 3
`define LSBCA_ST_BUSY 4
`define LSBCA_ST_SKIP 5
`define LSBCA_ST_BR 6

`define LSBCA_RST_WORD 16'h0000
`define LSBCA_CYC_BASE 3'h1
`define LSBCA_CYC_SKIP1 3'h2
`define LSBCA_CYC_SKIP2 3'h3
`define LSBCA_CYC_BR_ENH 3'h5
`define LSBCA_CYC_BR_LEGACY 3'h2

`endif

// file: logic/lsbca_pkg.sv
// types shared by the datapath slice and its helpers
// assumes the defines header sits on the include path
package lsbca_pkg;

  typedef enum logic [4:0] {
    logic_and_op = 5'h00, inclusive_or_op = 5'h01, exclusive_or_op = 5'h02,
    arith_right_shift_op = 5'h03, logical_right_shift_op = 5'h04,
    left_shift_op = 5'h05, rotate_left_carry_op = 5'h06,
    rotate_left_plain_op = 5'h07, rotate_right_carry_op = 5'h08,
    rotate_right_plain_op = 5'h09, bit_test_op = 5'h0A,
    bit_test_then_set_op = 5'h0B, sign_change_scan_op = 5'h0C,
    first_one_from_top_op = 5'h0D, first_one_from_bottom_op = 5'h0E,
    compare_op = 5'h0F, compare_borrow_op = 5'h10, compare_zero_op = 5'h11,
    skip_if_bit_clear_op = 5'h12, skip_if_bit_set_op = 5'h13,
    skip_if_greater_op = 5'h14, skip_if_less_op = 5'h15,
    skip_if_unequal_op = 5'h16, branch_if_equal_op = 5'h17,
    branch_if_unequal_op = 5'h18, branch_if_greater_op = 5'h19,
    branch_if_less_op = 5'h1A
  } lsbca_op_type;

  // operand form: file with working, register pair, register with literal
  typedef enum logic [1:0] {
    src_file = 2'h0, src_regs = 2'h1, src_lit = 2'h2
  } lsbca_src_type;

  typedef struct packed {
    logic sfr_access;
    logic enhanced;
    logic next_two_word;
    logic dest_default;
    lsbca_src_type src;
    logic [3:0] bit_pos;
    lsbca_op_type op;
  } lsbca_ctrl_type;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic c;
  } lsbca_flags_type;

  typedef enum logic [2:0] {
    st_idle = 3'b001, st_exec = 3'b010, st_hold = 3'b100
  } lsbca_state_type;

endpackage

// file: logic/lsbca_shifter.sv
// shift and rotate unit for one 16-bit operand
// assumes amount is zero to fifteen; carry passes through when unused
`timescale 1ns/1ps
`default_nettype none
module lsbca_shifter
  import lsbca_pkg::*;
(
  // operation
  input wire lsbca_pkg::lsbca_op_type op,
  input wire logic [15:0] val,
  input wire logic [3:0] amt,
  input wire logic cin,
  // result
  output logic [15:0] res,
  output logic cout
);
  logic [4:0] top_idx;
  logic [3:0] low_idx;

  always_comb
  begin
    top_idx = 5'd16 - {1'b0, amt};
    low_idx = amt - 4'h1;
    res = val;
    cout = cin;
    unique case (op)
      arith_right_shift_op:
      begin
        res = $signed(val) >>> amt;
        cout = (amt == 4'h0) ? cin : val[low_idx];
      end
      logical_right_shift_op:
      begin
        res = val >> amt;
        cout = (amt == 4'h0) ? cin : val[low_idx];
      end
      left_shift_op:
      begin
        res = val << amt;
        cout = (amt == 4'h0) ? cin : val[top_idx[3:0]];
      end
      rotate_left_carry_op: {cout, res} = {val, cin};
      rotate_right_carry_op: {res, cout} = {cin, val};
      rotate_left_plain_op: res = {val[14:0], val[15]};
      rotate_right_plain_op: res = {val[0], val[15:1]};
      default:
      begin
        res = val;
        cout = cin;
      end
    endcase
  end
endmodule
`default_nettype wire

// file: logic/lsbca_scan.sv
// finds the first set bit from the top of a 16-bit vector
// position counts 1 for bit 15 up to 16 for bit 0; 0 when none
`timescale 1ns/1ps
`default_nettype none
module lsbca_scan
(
  // vector
  input wire logic [15:0] vec,
  // answer
  output logic [4:0] pos,
  output logic found
);
  always_comb
  begin
    pos = 5'h00;
    found = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      if (!found && vec[i])
      begin
        found = 1'b1;
        pos = 5'(16 - i);
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/lsbca_alu.sv
// logic, shift, bit and compare datapath slice behind an AHB-Lite slave
// assumes a single master, single word transfers, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "lsbca_defines.svh"
module lsbca_alu
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // sequencer outcome
  output logic seq_skip,
  output logic seq_branch,
  output logic [2:0] seq_cycles,
  output logic alu_busy
);
  import lsbca_pkg::*;

  logic rd_pend_q;
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_val;
  logic accept;

  lsbca_ctrl_type ctrl_q;
  lsbca_state_type state_q;
  logic [2:0] hold_q;
  logic [15:0] opa_q;
  logic [15:0] opb_q;
  logic [15:0] lit_q;
  logic [15:0] file_q;
  logic [15:0] default_working_register_q;
  logic [15:0] dest_q;
  lsbca_flags_type flags_q;
  lsbca_flags_type flags_d;
  logic skip_q;
  logic branch_q;
  logic [2:0] cyc_q;

  logic go;
  logic wr_en;
  logic [15:0] o1;
  logic [15:0] o2;
  logic [3:0] amt;
  logic [3:0] bsel;
  logic bit_val;
  logic [15:0] res;
  logic to_file;
  logic to_default;
  logic to_dest;
  logic to_opa;
  logic skip_d;
  logic branch_d;
  logic [2:0] cyc_d;
  logic [16:0] diff;
  logic borrow_in;
  logic [15:0] sh_res;
  logic sh_c;
  logic [4:0] top_pos;
  logic top_found;
  logic [4:0] bot_pos;
  logic bot_found;
  logic [4:0] chg_pos;
  logic chg_found;
  logic [15:0] rev_a;
  logic [15:0] chg_vec;

  // bus side: reads take one wait state so hrdata comes from a flop
  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = !rd_pend_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wr_en = wr_pend_q;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (hreadyout)
      begin
        rd_pend_q <= accept && !hwrite;
        wr_pend_q <= accept && hwrite;
        if (accept)
        begin
          addr_q <= (haddr[31:8] == 24'h0) ? {haddr[7:2], 2'b00} : 8'hFC;
        end
      end
      else
      begin
        rd_pend_q <= 1'b0;
        hrdata_q <= rd_val;
      end
    end
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (addr_q)
      `LSBCA_OFF_CTRL: rd_val = {17'h0, ctrl_q};
      `LSBCA_OFF_OPA: rd_val = {16'h0, opa_q};
      `LSBCA_OFF_OPB: rd_val = {16'h0, opb_q};
      `LSBCA_OFF_LIT: rd_val = {16'h0, lit_q};
      `LSBCA_OFF_FILE: rd_val = {16'h0, file_q};
      `LSBCA_OFF_DEFWR: rd_val = {16'h0, default_working_register_q};
      `LSBCA_OFF_DEST: rd_val = {16'h0, dest_q};
      `LSBCA_OFF_STAT: rd_val = {25'h0, branch_q, skip_q, alu_busy,
                                 flags_q.n, flags_q.ov, flags_q.z, flags_q.c};
      `LSBCA_OFF_CYC: rd_val = {29'h0, cyc_q};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // a control write starts one operation; ignored while busy
  assign go = wr_en && (addr_q == `LSBCA_OFF_CTRL) && (state_q == st_idle);
  assign alu_busy = (state_q != st_idle);

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= st_idle;
      ctrl_q <= '0;
      hold_q <= 3'h0;
    end
    else
    begin
      unique case (state_q)
        st_idle:
        begin
          if (go)
          begin
            ctrl_q <= lsbca_ctrl_type'(hwdata[`LSBCA_CTRL_W-1:0]);
            state_q <= st_exec;
          end
        end
        st_exec:
        begin
          hold_q <= cyc_d - 3'h1;
          state_q <= (cyc_d > `LSBCA_CYC_BASE) ? st_hold : st_idle;
        end
        st_hold:
        begin
          hold_q <= hold_q - 3'h1;
          if (hold_q <= 3'h1)
          begin
            state_q <= st_idle;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // operand selection by form
  always_comb
  begin
    o1 = (ctrl_q.src == src_file) ? file_q : opa_q;
    unique case (ctrl_q.src)
      src_file: o2 = default_working_register_q;
      src_regs: o2 = opb_q;
      default: o2 = lit_q;
    endcase
    unique case (ctrl_q.src)
      src_regs: amt = opb_q[3:0];
      src_lit: amt = lit_q[3:0];
      default: amt = 4'h1;
    endcase
    bsel = (ctrl_q.src == src_regs) ? opb_q[3:0] : ctrl_q.bit_pos;
    bit_val = o1[bsel];
    rev_a = {<<{opa_q}};
    chg_vec = {opa_q[14:0] ^ {15{opa_q[15]}}, 1'b0};
  end

  lsbca_shifter u_shift (
    .op(ctrl_q.op),
    .val(o1),
    .amt(amt),
    .cin(flags_q.c),
    .res(sh_res),
    .cout(sh_c)
  );

  lsbca_scan u_scan_top (
    .vec(opa_q),
    .pos(top_pos),
    .found(top_found)
  );

  lsbca_scan u_scan_bot (
    .vec(rev_a),
    .pos(bot_pos),
    .found(bot_found)
  );

  lsbca_scan u_scan_chg (
    .vec(chg_vec),
    .pos(chg_pos),
    .found(chg_found)
  );

  // compare subtractor
  always_comb
  begin
    borrow_in = (ctrl_q.op == compare_borrow_op) && !flags_q.c;
    diff = {1'b0, o1} - {1'b0, (ctrl_q.op == compare_zero_op) ? 16'h0000 : o2}
           - {16'h0000, borrow_in};
  end

  // result, destination and flags of the operation in flight
  always_comb
  begin
    res = o1;
    flags_d = flags_q;
    to_file = 1'b0;
    to_default = 1'b0;
    to_dest = 1'b0;
    to_opa = 1'b0;
    skip_d = 1'b0;
    branch_d = 1'b0;
    unique case (ctrl_q.op)
      logic_and_op, inclusive_or_op, exclusive_or_op,
      arith_right_shift_op, logical_right_shift_op, left_shift_op,
      rotate_left_carry_op, rotate_left_plain_op,
      rotate_right_carry_op, rotate_right_plain_op:
      begin
        if (ctrl_q.op == logic_and_op)
          res = o1 & o2;
        else if (ctrl_q.op == inclusive_or_op)
          res = o1 | o2;
        else if (ctrl_q.op == exclusive_or_op)
          res = o1 ^ o2;
        else
        begin
          res = sh_res;
          flags_d.c = sh_c;
        end
        flags_d.z = (res == 16'h0000);
        flags_d.n = res[15];
        to_default = (ctrl_q.src == src_file) && ctrl_q.dest_default;
        to_file = (ctrl_q.src == src_file) && !ctrl_q.dest_default;
        to_dest = (ctrl_q.src != src_file);
      end
      bit_test_op, bit_test_then_set_op:
      begin
        res = o1 | (16'h0001 << bsel);
        if (ctrl_q.src == src_file)
          flags_d.z = !bit_val;
        else
          flags_d.c = bit_val;
        if (ctrl_q.op == bit_test_then_set_op)
        begin
          to_file = (ctrl_q.src == src_file);
          to_opa = (ctrl_q.src != src_file);
        end
      end
      sign_change_scan_op:
      begin
        res = chg_found ? {11'h0, chg_pos - 5'h1} : 16'h0000;
        flags_d.c = !chg_found;
        to_dest = 1'b1;
      end
      first_one_from_top_op, first_one_from_bottom_op:
      begin
        if (ctrl_q.op == first_one_from_top_op)
          res = {11'h0, top_pos};
        else
          res = {11'h0, bot_pos};
        flags_d.c = (ctrl_q.op == first_one_from_top_op) ? !top_found : !bot_found;
        to_dest = 1'b1;
      end
      compare_op, compare_borrow_op, compare_zero_op:
      begin
        flags_d.c = !diff[16];
        flags_d.n = diff[15];
        flags_d.ov = (o1[15] ^ o2[15]) & (o1[15] ^ diff[15]);
        if (ctrl_q.op == compare_borrow_op)
          flags_d.z = flags_q.z && (diff[15:0] == 16'h0000);
        else
          flags_d.z = (diff[15:0] == 16'h0000);
        if (ctrl_q.op == compare_zero_op)
          flags_d.ov = 1'b0;
      end
      skip_if_bit_clear_op: skip_d = !bit_val;
      skip_if_bit_set_op: skip_d = bit_val;
      skip_if_greater_op: skip_d = $signed(opa_q) > $signed(opb_q);
      skip_if_less_op: skip_d = $signed(opa_q) < $signed(opb_q);
      skip_if_unequal_op: skip_d = (opa_q != opb_q);
      branch_if_equal_op: branch_d = (opa_q == opb_q);
      branch_if_unequal_op: branch_d = (opa_q != opb_q);
      branch_if_greater_op: branch_d = $signed(opa_q) > $signed(opb_q);
      branch_if_less_op: branch_d = $signed(opa_q) < $signed(opb_q);
      default: res = o1;
    endcase
  end

  // cycle cost of the operation
  always_comb
  begin
    cyc_d = `LSBCA_CYC_BASE;
    if (skip_d)
      cyc_d = ctrl_q.next_two_word ? `LSBCA_CYC_SKIP2 : `LSBCA_CYC_SKIP1;
    else if (branch_d)
      cyc_d = ctrl_q.enhanced ? `LSBCA_CYC_BR_ENH : `LSBCA_CYC_BR_LEGACY;
    if (ctrl_q.enhanced && ctrl_q.sfr_access && (ctrl_q.src == src_file))
      cyc_d = cyc_d + 3'h1;
  end

  // operand and result registers; the executing operation wins a clash
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      opa_q <= `LSBCA_RST_WORD;
      opb_q <= `LSBCA_RST_WORD;
      lit_q <= `LSBCA_RST_WORD;
      file_q <= `LSBCA_RST_WORD;
      default_working_register_q <= `LSBCA_RST_WORD;
      dest_q <= `LSBCA_RST_WORD;
    end
    else
    begin
      if (wr_en && addr_q == `LSBCA_OFF_OPB)
        opb_q <= hwdata[15:0];
      if (wr_en && addr_q == `LSBCA_OFF_LIT)
        lit_q <= hwdata[15:0];
      if (state_q == st_exec && to_opa)
        opa_q <= res;
      else if (wr_en && addr_q == `LSBCA_OFF_OPA)
        opa_q <= hwdata[15:0];
      if (state_q == st_exec && to_file)
        file_q <= res;
      else if (wr_en && addr_q == `LSBCA_OFF_FILE)
        file_q <= hwdata[15:0];
      if (state_q == st_exec && to_default)
        default_working_register_q <= res;
      else if (wr_en && addr_q == `LSBCA_OFF_DEFWR)
        default_working_register_q <= hwdata[15:0];
      if (state_q == st_exec && to_dest)
        dest_q <= res;
      else if (wr_en && addr_q == `LSBCA_OFF_DEST)
        dest_q <= hwdata[15:0];
    end
  end

  // status flags and sequencer outcome
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags_q <= '0;
      skip_q <= 1'b0;
      branch_q <= 1'b0;
      cyc_q <= 3'h0;
      seq_skip <= 1'b0;
      seq_branch <= 1'b0;
      seq_cycles <= 3'h0;
    end
    else
    begin
      seq_skip <= (state_q == st_exec) && skip_d;
      seq_branch <= (state_q == st_exec) && branch_d;
      if (state_q == st_exec)
      begin
        flags_q <= flags_d;
        skip_q <= skip_d;
        branch_q <= branch_d;
        cyc_q <= cyc_d;
        seq_cycles <= cyc_d;
      end
      else if (wr_en && addr_q == `LSBCA_OFF_STAT)
      begin
        flags_q <= lsbca_flags_type'(hwdata[3:0]);
      end
    end
  end
endmodule
`default_nettype wire

// file: test/lsbca_alu_chk.sv
// concurrent checks on the datapath slice ports
// assumes one clock domain and a single bus master
`timescale 1ns/1ps
`default_nettype none
module lsbca_alu_chk
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // sequencer outcome
  input wire logic seq_skip,
  input wire logic seq_branch,
  input wire logic [2:0] seq_cycles,
  input wire logic alu_busy
);
  logic [2:0] busy_cnt_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // length of the current busy run
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy_cnt_q <= 3'h0;
    else if (alu_busy)
      busy_cnt_q <= busy_cnt_q + 3'h1;
    else
      busy_cnt_q <= 3'h0;
  end
  sequence s_rd_taken;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_wr_taken;
    hsel && htrans[1] && hready && hwrite;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_one_wait: assert property (s_rd_taken |=> s_one_wait)
    else $error("read data phase wait count wrong");
  a_write_no_wait: assert property (s_wr_taken |=> hreadyout)
    else $error("write data phase stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_upper_zero: assert property (hrdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_skip_cost: assert property (seq_skip |-> seq_cycles inside {3'h2, 3'h3})
    else $error("taken skip cost wrong");
  a_branch_cost: assert property (seq_branch |-> seq_cycles inside {3'h2, 3'h5})
    else $error("taken branch cost wrong");
  a_pulse_single: assert property ((seq_skip || seq_branch) |=> !(seq_skip || seq_branch))
    else $error("outcome pulse too long");
  a_outcome_excl: assert property (!(seq_skip && seq_branch))
    else $error("skip and branch together");
  a_busy_span: assert property ($fell(alu_busy) |-> busy_cnt_q == seq_cycles)
    else $error("busy length differs from cycle cost");
  a_cycles_hold: assert property (!$stable(seq_cycles) |-> $past(alu_busy))
    else $error("cycle cost changed while idle");
endmodule
bind lsbca_alu lsbca_alu_chk u_chk (.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
  .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .seq_skip, .seq_branch,
  .seq_cycles, .alu_busy);
`default_nettype wire

// file: test/lsbca_seq_model.sv
// sequencer model that records skip and branch outcomes of each operation
// assumes an operation starts when busy rises
`timescale 1ns/1ps
`default_nettype none
module lsbca_seq_model
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // outcome from the slice
  input wire logic alu_busy,
  input wire logic seq_skip,
  input wire logic seq_branch,
  // outcomes seen since the operation began
  output logic [1:0] seen
);
  logic busy_q;
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy_q <= 1'b0;
    else
      busy_q <= alu_busy;
  end
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      seen <= 2'h0;
    else if (alu_busy && !busy_q)
      seen <= 2'h0;
    else
      seen <= seen | {seq_branch, seq_skip};
  end
endmodule
`default_nettype wire

// file: test/test_lsbca_alu.sv
// self-checking bench for the datapath slice
// assumes the defines header on the include path; hready loops back from hreadyout
`timescale 1ns/1ps
`default_nettype none
`include "lsbca_defines.svh"
module test_lsbca_alu;
  import lsbca_pkg::*;
  typedef struct packed {
    logic [15:0] c, a, b, f, w;
    logic [3:0] s;
    logic [7:0] ad;
    logic [15:0] e;
    logic [3:0] fm, fe;
    logic [1:0] p;
  } lsbca_row_type;
  localparam logic [7:0] oc = `LSBCA_OFF_CTRL, oa = `LSBCA_OFF_OPA, ob = `LSBCA_OFF_OPB,
    ol = `LSBCA_OFF_LIT, of = `LSBCA_OFF_FILE, ow = `LSBCA_OFF_DEFWR, od = `LSBCA_OFF_DEST,
    os = `LSBCA_OFF_STAT, oy = `LSBCA_OFF_CYC;
  logic sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, seq_skip, seq_branch, alu_busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, seen;
  logic [2:0] hsize, seq_cycles;
  logic [15:0] q;
  int n_errors, n_checks;
  lsbca_row_type rows[$];
  lsbca_alu dut (.sys_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .seq_skip, .seq_branch,
    .seq_cycles, .alu_busy);
  lsbca_seq_model u_seq (.sys_clk, .sys_rst, .alu_busy, .seq_skip, .seq_branch, .seen);
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for a level on one design output
  task automatic wait_for(input bit rdy, input logic lvl);
    int i;
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if ((rdy ? hreadyout : alu_busy) === lvl)
        break;
    end
    if (i == 20)
    begin
      n_errors++;
      $display("ERROR %0t: wait ran out", $time);
      end_of_test;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [15:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, ad};
    hwrite <= wr;
    wait_for(1'b1, 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    wait_for(1'b1, 1'b1);
    q = hrdata[15:0];
  endtask
  function automatic logic [15:0] k(lsbca_op_type o, logic [3:0] bp, lsbca_src_type sr,
    logic [3:0] x);
    return {1'b0, x, sr, bp, o};
  endfunction
  task r(input logic [15:0] c, a, b, f, w, input logic [3:0] s, input logic [7:0] ad,
    input logic [15:0] e, input logic [3:0] fm, fe, input logic [1:0] p);
    rows.push_back('{c, a, b, f, w, s, ad, e, fm, fe, p});
  endtask
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    sys_rst = 1'b1;
    n_errors = 0;
    n_checks = 0;
    r(k(logic_and_op,0,src_regs,0),16'hF0F0,16'hFF00,0,0,0,od,16'hF000,4'hA,4'h8,0);
    r(k(inclusive_or_op,0,src_file,0),0,0,16'h0F00,16'h00F0,0,of,16'h0FF0,0,0,0);
    r(k(exclusive_or_op,0,src_file,1),0,0,16'hAAAA,16'hFFFF,0,ow,16'h5555,0,0,0);
    r(k(exclusive_or_op,0,src_file,1),0,0,16'hAAAA,16'hFFFF,0,of,16'hAAAA,0,0,0);
    r(k(exclusive_or_op,0,src_lit,0),16'h00FF,16'h0F0F,0,0,0,od,16'h0FF0,4'h2,0,0);
    r(k(arith_right_shift_op,0,src_regs,0),16'h8001,1,0,0,0,od,16'hC000,1,1,0);
    r(k(arith_right_shift_op,0,src_lit,0),16'h8000,16'hF,0,0,0,od,16'hFFFF,1,0,0);
    r(k(logical_right_shift_op,0,src_lit,0),16'h8003,2,0,0,0,od,16'h2000,1,1,0);
    r(k(left_shift_op,0,src_regs,0),16'hC001,1,0,0,0,od,16'h8002,1,1,0);
    r(k(left_shift_op,0,src_lit,0),1,16'hF,0,0,0,od,16'h8000,1,0,0);
    r(k(rotate_left_carry_op,0,src_file,0),0,0,16'h8000,0,0,of,16'h0000,1,1,0);
    r(k(rotate_right_carry_op,0,src_regs,0),1,1,0,0,1,od,16'h8000,1,1,0);
    r(k(rotate_left_plain_op,0,src_regs,0),16'h8001,1,0,0,1,od,16'h0003,1,1,0);
    r(k(rotate_right_plain_op,0,src_regs,0),1,1,0,0,0,od,16'h8000,1,0,0);
    r(k(bit_test_then_set_op,3,src_file,0),0,0,0,0,0,of,16'h0008,4'h2,4'h2,0);
    r(k(bit_test_op,0,src_regs,0),16'h0020,5,0,0,0,od,16'h5A5A,1,1,0);
    r(k(sign_change_scan_op,0,src_regs,0),16'hF000,0,0,0,0,od,16'h0003,0,0,0);
    r(k(first_one_from_top_op,0,src_regs,0),16'h0100,0,0,0,0,od,16'h0008,0,0,0);
    r(k(first_one_from_bottom_op,0,src_regs,0),16'h0100,0,0,0,0,od,16'h0009,0,0,0);
    r(k(compare_op,0,src_regs,0),5,5,0,0,0,od,16'h5A5A,4'h3,4'h3,0);
    r(k(compare_op,0,src_file,0),0,0,16'h1234,16'h1234,0,of,16'h1234,4'h3,4'h3,0);
    r(k(compare_borrow_op,0,src_regs,0),5,5,0,0,4'h2,od,16'h5A5A,4'h3,0,0);
    r(k(compare_borrow_op,0,src_regs,0),5,5,0,0,4'h3,od,16'h5A5A,4'h3,4'h3,0);
    r(k(compare_zero_op,0,src_regs,0),0,0,0,0,0,oy,1,4'h2,4'h2,0);
    r(k(skip_if_bit_clear_op,0,src_regs,0),0,3,0,0,0,oy,2,0,0,1);
    r(k(skip_if_bit_clear_op,0,src_regs,2),0,3,0,0,0,oy,3,0,0,1);
    r(k(skip_if_bit_set_op,0,src_regs,0),0,3,0,0,0,oy,1,0,0,0);
    r(k(skip_if_bit_set_op,4,src_file,0),0,0,16'h0010,0,0,of,16'h0010,0,0,1);
    r(k(skip_if_greater_op,0,src_regs,0),1,16'hFFFF,0,0,0,oy,2,0,0,1);
    r(k(skip_if_less_op,0,src_regs,0),1,16'hFFFF,0,0,0,oy,1,0,0,0);
    r(k(skip_if_unequal_op,0,src_regs,0),1,1,0,0,0,oy,1,0,0,0);
    r(k(branch_if_equal_op,0,src_regs,4),7,7,0,0,0,oy,5,0,0,2);
    r(k(branch_if_unequal_op,0,src_regs,4),7,7,0,0,0,oy,1,0,0,0);
    r(k(branch_if_greater_op,0,src_regs,4),1,16'h8000,0,0,0,oy,5,0,0,2);
    r(k(branch_if_less_op,0,src_regs,0),16'h8000,1,0,0,0,oy,2,0,0,2);
    r(k(bit_test_then_set_op,2,src_lit,0),1,0,0,0,0,oa,16'h0005,1,0,0);
    r(k(bit_test_op,2,src_file,0),0,0,16'h0004,0,4'h2,of,16'h0004,4'h2,0,0);
    r(k(compare_op,0,src_lit,0),16'h8000,1,0,0,0,od,16'h5A5A,4'hF,4'h5,0);
    r(k(skip_if_less_op,0,src_regs,0),16'hFFFF,1,0,0,0,oy,2,0,0,1);
    r(k(skip_if_unequal_op,0,src_regs,2),1,2,0,0,0,oy,3,0,0,1);
    r(k(branch_if_unequal_op,0,src_regs,4),7,8,0,0,0,oy,5,0,0,2);
    r(k(logic_and_op,0,src_file,4'hC),0,0,0,0,0,oy,2,0,0,0);
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    for (int j = 0; j < 9; j++)
    begin
      bus(1'b0, 8'(j * 4), 16'h0000);
      chk(q, 16'h0000);
    end
    foreach (rows[i])
    begin
      bus(1'b1, oa, rows[i].a);
      bus(1'b1, ob, rows[i].b);
      bus(1'b1, ol, rows[i].b);
      bus(1'b1, of, rows[i].f);
      bus(1'b1, ow, rows[i].w);
      bus(1'b1, os, {12'h000, rows[i].s});
      bus(1'b1, od, 16'h5A5A);
      bus(1'b1, oc, rows[i].c);
      wait_for(1'b0, 1'b0);
      bus(1'b0, rows[i].ad, 16'h0000);
      chk(q, rows[i].e);
      bus(1'b0, os, 16'h0000);
      chk(q & {12'h000, rows[i].fm}, {12'h000, rows[i].fe});
      chk({14'h0000, seen}, {14'h0000, rows[i].p});
    end
    bus(1'b1, oc, k(branch_if_equal_op, 0, src_regs, 4'h4));
    bus(1'b1, oc, k(logic_and_op, 0, src_regs, 4'h0));
    wait_for(1'b0, 1'b0);
    bus(1'b0, oy, 16'h0000);
    chk(q, 16'h0005);
    bus(1'b0, od, 16'h0000);
    chk(q, 16'h5A5A);
    bus(1'b1, 8'h40, 16'hFFFF);
    bus(1'b0, 8'h40, 16'h0000);
    chk(q, 16'h0000);
    bus(1'b1, ow, 16'h1234);
    bus(1'b0, ow, 16'h0000);
    chk(q, 16'h1234);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    bus(1'b0, ow, 16'h0000);
    chk(q, 16'h0000);
    end_of_test;
  end
endmodule
`default_nettype wire
